/* uart_irq_pkg.sv */
`default_nettype none
package uart_irq_pkg;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam int          ADDR_W        = 3;
  localparam logic [2:0]  ADDR_ENABLE   = 3'h1;
  localparam logic [2:0]  ADDR_IDENTIFY = 3'h2;
  localparam logic [7:0]  ENABLE_RST    = 8'h00;
  localparam logic [7:0]  RDATA_IDLE    = 8'h00;

  // enable register bit positions
  localparam int EN_RXDATA = 0;
  localparam int EN_THR    = 1;
  localparam int EN_LSR    = 2;
  localparam int EN_MODEM  = 3;
  localparam int EN_SLEEP  = 4;
  localparam int EN_XOFF   = 5;
  localparam int EN_RTS    = 6;
  localparam int EN_CTS    = 7;

  // enhanced bits 7:4 only take effect with the enhanced-function enable
  localparam logic [7:0] EN_BASIC_MASK = 8'h0f;
  localparam logic [7:0] EN_FULL_MASK  = 8'hff;

  // ==========================================================================
  // identify register bits 5:0 per priority level
  // ==========================================================================
  localparam logic [5:0] ID_LSR    = 6'h06;
  localparam logic [5:0] ID_TOUT   = 6'h0c;
  localparam logic [5:0] ID_RXDATA = 6'h04;
  localparam logic [5:0] ID_THR    = 6'h02;
  localparam logic [5:0] ID_MODEM  = 6'h00;
  localparam logic [5:0] ID_XOFF   = 6'h10;
  localparam logic [5:0] ID_FLOW   = 6'h20;
  localparam logic [5:0] ID_NONE   = 6'h01;

  // ==========================================================================
  // receive time-out: four character times plus twelve bit times
  // ==========================================================================
  localparam int TOUT_CHARS = 4;
  localparam int TOUT_EXTRA = 12;

  // presented priority level, one-hot
  typedef enum logic [7:0] {
    LVL_NONE   = 8'h01,
    LVL_LSR    = 8'h02,
    LVL_TOUT   = 8'h04,
    LVL_RXDATA = 8'h08,
    LVL_THR    = 8'h10,
    LVL_MODEM  = 8'h20,
    LVL_XOFF   = 8'h40,
    LVL_FLOW   = 8'h80
  } level_t;

endpackage
`default_nettype wire

/* uart_channel_interrupt_logic.sv */
// Notes on behaviour
// RL1: each of seven sources can raise irqOut alone once its enable bit is one
// RL2: masked sources never raise irqOut, save a cts/rts rise caught before its bit cleared; status tracking still runs
// RL3: enable bit 7 allows interrupt on rising cts, only with enhanced enable
// RL4: enable bit 6 allows interrupt on rising rts, only with enhanced enable
// RL5: enable bit 5 allows interrupt on stop character, only with enhanced enable
// RL6: enable bit 4 selects sleep mode when enhanced enable is one
// RL7: enable bit 3 unmasks the modem status interrupt
// RL8: enable bit 2 unmasks line status interrupt, raised by any of bits 4:1
// RL9: overrun flag raises its interrupt as soon as the overflowing frame arrives
// RL10: break, framing, parity raise interrupt when the bad character is read
// RL11: enable bit 1 unmasks the transmit holding empty interrupt
// RL12: enable bit 0 unmasks receive data available and receive time-out
// RL13: all enable bits reset to zero
// RL14: identify read freezes and presents the highest of seven levels
// RL15: new events keep recording during a read; presented value stays fixed
// RL16: identify bits 7:6 read 11 with FIFOs enabled, 00 otherwise
// RL17: identify bit 5 set when rts or cts rose
// RL18: identify bit 4 set on stop or special character match
// RL19: identify bit 0 is zero while anything pends, one otherwise and at reset
// RL20: levels 1 to 3 read 000110, 001100, 000100
// RL21: level 4 reads 000010, level 5 reads 000000
// RL22: level 6 reads 010000, level 7 100000, idle 000001
// RL23: transmit empty interrupt clears on identify read or transmit write
// RL24: trigger-level interrupt holds until fill count drops below trigger
// RL25: time-out fires after 4 characters plus 12 bits idle, clears on data read
// RL26: stop/special interrupt clears on identify read or resume char; special also on next char
// RL27: irqOut is high exactly while identify bit 0 shows a pending interrupt
`timescale 1ns/10ps
`default_nettype none

module uart_channel_interrupt_logic #(
  parameter int CHAR_BITS  = 10,
  parameter int FIFO_CNT_W = 7
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic [2:0]            regAddr,
  input  wire logic [7:0]            regWrData,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic      [7:0]            regRdData,
  input  wire logic                  enhanced,
  input  wire logic                  fifoEnable,
  input  wire logic                  overrunEvt,
  input  wire logic                  errRead,
  input  wire logic [2:0]            errBits,
  input  wire logic                  lsrRead,
  input  wire logic [FIFO_CNT_W-1:0] rxFill,
  input  wire logic [FIFO_CNT_W-1:0] rxTrig,
  input  wire logic                  rxCharEvt,
  input  wire logic                  rxDataRead,
  input  wire logic                  bitTick,
  input  wire logic                  txEmpty,
  input  wire logic                  txWrite,
  input  wire logic [3:0]            msrDelta,
  input  wire logic                  msrRead,
  input  wire logic                  xoffMatch,
  input  wire logic                  specialMatch,
  input  wire logic                  xonMatch,
  input  wire logic                  cts,
  input  wire logic                  rts,
  output logic                       irqOut,
  output logic                       sleepMode,
  output logic      [3:0]            lineErr
);

  // ==========================================================================
  // state
  // ==========================================================================
  localparam int         TOUT_BITS = uart_irq_pkg::TOUT_CHARS * CHAR_BITS
                                     + uart_irq_pkg::TOUT_EXTRA;
  localparam logic [7:0] TOUT_CNT  = 8'(TOUT_BITS);

  typedef struct packed {
    logic [7:0]           enable;
    logic [3:0]           lineErr;
    logic [7:0]           toutCnt;
    logic                 toutFlag;
    logic                 thrFlag;
    logic                 txEmptyPrev;
    logic                 xoffFlag;
    logic                 xoffSpecial;
    logic                 ctsPrev;
    logic                 rtsPrev;
    logic                 flowFlag;
    uart_irq_pkg::level_t level;
    logic                 irq;
    logic [7:0]           rdData;
  } state_t;

  state_t     st_ff;
  state_t     nxt_st;
  logic [7:0] effEn;
  logic       idRead;
  logic       counting;
  logic       dataReady;

  function automatic logic [5:0] levelCode(input uart_irq_pkg::level_t lvl);
    case (lvl)
      uart_irq_pkg::LVL_LSR:    levelCode = uart_irq_pkg::ID_LSR;    // RL20
      uart_irq_pkg::LVL_TOUT:   levelCode = uart_irq_pkg::ID_TOUT;   // RL20
      uart_irq_pkg::LVL_RXDATA: levelCode = uart_irq_pkg::ID_RXDATA; // RL20
      uart_irq_pkg::LVL_THR:    levelCode = uart_irq_pkg::ID_THR;    // RL21
      uart_irq_pkg::LVL_MODEM:  levelCode = uart_irq_pkg::ID_MODEM;  // RL21
      uart_irq_pkg::LVL_XOFF:   levelCode = uart_irq_pkg::ID_XOFF;   // RL22 RL18
      uart_irq_pkg::LVL_FLOW:   levelCode = uart_irq_pkg::ID_FLOW;   // RL22 RL17
      default:                  levelCode = uart_irq_pkg::ID_NONE;   // RL22 RL19
    endcase
  endfunction

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    nxt_st = st_ff;
    effEn  = st_ff.enable & (enhanced ? uart_irq_pkg::EN_FULL_MASK
                                      : uart_irq_pkg::EN_BASIC_MASK); // RL3 RL4 RL5 RL6
    idRead = regRd && (regAddr == uart_irq_pkg::ADDR_IDENTIFY);

    // line status keeps tracking whatever the mask; set wins over the clear
    nxt_st.lineErr = (st_ff.lineErr & {4{~lsrRead}})
                     | {(errRead ? errBits : 3'h0), overrunEvt}; // RL2 RL9 RL10

    // transmit empty edge, cleared by a presented identify read or a new byte
    nxt_st.txEmptyPrev = txEmpty;
    nxt_st.thrFlag = (txEmpty & ~st_ff.txEmptyPrev)
                     | (st_ff.thrFlag & ~(txWrite
                        | (idRead && st_ff.level == uart_irq_pkg::LVL_THR))); // RL23

    // time-out counts bit ticks in FIFO mode while data waits and nothing happens
    counting = fifoEnable && (rxFill != '0) && !rxCharEvt && !rxDataRead;
    if (!counting) begin
      nxt_st.toutCnt = 8'h00;
    end else if (bitTick && st_ff.toutCnt != TOUT_CNT) begin
      nxt_st.toutCnt = st_ff.toutCnt + 8'h01;
    end
    nxt_st.toutFlag = (counting && bitTick && st_ff.toutCnt == TOUT_CNT - 8'h01)
                      | (st_ff.toutFlag & ~rxDataRead); // RL25

    // trigger level in FIFO mode, any character otherwise
    dataReady = fifoEnable ? ((rxFill >= rxTrig) && (rxFill != '0))
                           : (rxFill != '0); // RL24

    // stop or special character; special also ends on the next character
    if (xoffMatch || specialMatch) begin
      nxt_st.xoffFlag    = 1'b1;
      nxt_st.xoffSpecial = specialMatch & ~xoffMatch;
    end else if (xonMatch || (st_ff.xoffSpecial && rxCharEvt)
                 || (idRead && st_ff.level == uart_irq_pkg::LVL_XOFF)) begin
      nxt_st.xoffFlag    = 1'b0; // RL26
      nxt_st.xoffSpecial = 1'b0;
    end

    // flow-control pin rises, only caught while enabled so stale edges stay out
    nxt_st.ctsPrev = cts;
    nxt_st.rtsPrev = rts;
    nxt_st.flowFlag = (cts & ~st_ff.ctsPrev & effEn[uart_irq_pkg::EN_CTS])   // RL3
                      | (rts & ~st_ff.rtsPrev & effEn[uart_irq_pkg::EN_RTS]) // RL4
                      | (st_ff.flowFlag & ~(msrRead
                         || (idRead && st_ff.level == uart_irq_pkg::LVL_FLOW)));

    // priority resolution of unmasked sources
    if (effEn[uart_irq_pkg::EN_LSR] && st_ff.lineErr != 4'h0) begin
      nxt_st.level = uart_irq_pkg::LVL_LSR; // RL8
    end else if (effEn[uart_irq_pkg::EN_RXDATA] && st_ff.toutFlag) begin
      nxt_st.level = uart_irq_pkg::LVL_TOUT; // RL12
    end else if (effEn[uart_irq_pkg::EN_RXDATA] && dataReady) begin
      nxt_st.level = uart_irq_pkg::LVL_RXDATA; // RL12
    end else if (effEn[uart_irq_pkg::EN_THR] && st_ff.thrFlag) begin
      nxt_st.level = uart_irq_pkg::LVL_THR; // RL11
    end else if (effEn[uart_irq_pkg::EN_MODEM] && msrDelta != 4'h0) begin
      nxt_st.level = uart_irq_pkg::LVL_MODEM; // RL7
    end else if (effEn[uart_irq_pkg::EN_XOFF] && st_ff.xoffFlag) begin
      nxt_st.level = uart_irq_pkg::LVL_XOFF; // RL5
    end else if (st_ff.flowFlag) begin
      nxt_st.level = uart_irq_pkg::LVL_FLOW; // RL3 RL4
    end else begin
      nxt_st.level = uart_irq_pkg::LVL_NONE; // RL2
    end
    nxt_st.irq = (nxt_st.level != uart_irq_pkg::LVL_NONE); // RL1 RL27

    // read returns the level registered before the strobe, so it cannot
    // shift under the access while new events keep landing in the flags
    nxt_st.rdData = uart_irq_pkg::RDATA_IDLE;
    if (regRd) begin
      case (regAddr)
        uart_irq_pkg::ADDR_ENABLE: begin
          nxt_st.rdData = st_ff.enable;
        end
        uart_irq_pkg::ADDR_IDENTIFY: begin
          nxt_st.rdData = {{2{fifoEnable}}, levelCode(st_ff.level)}; // RL14 RL15 RL16
        end
        default: begin
          nxt_st.rdData = uart_irq_pkg::RDATA_IDLE;
        end
      endcase
    end

    if (regWr && regAddr == uart_irq_pkg::ADDR_ENABLE) begin
      nxt_st.enable = regWrData; // RL1
    end
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff.enable      <= uart_irq_pkg::ENABLE_RST; // RL13
      st_ff.lineErr     <= 4'h0;
      st_ff.toutCnt     <= 8'h00;
      st_ff.toutFlag    <= 1'b0;
      st_ff.thrFlag     <= 1'b0;
      st_ff.txEmptyPrev <= 1'b0;
      st_ff.xoffFlag    <= 1'b0;
      st_ff.xoffSpecial <= 1'b0;
      st_ff.ctsPrev     <= 1'b0;
      st_ff.rtsPrev     <= 1'b0;
      st_ff.flowFlag    <= 1'b0;
      st_ff.level       <= uart_irq_pkg::LVL_NONE; // RL19
      st_ff.irq         <= 1'b0;
      st_ff.rdData      <= uart_irq_pkg::RDATA_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign regRdData = st_ff.rdData;
  assign irqOut    = st_ff.irq;
  assign lineErr   = st_ff.lineErr;
  // sleep is a level to the rest of the channel; it drops with the enable bit
  assign sleepMode = st_ff.enable[uart_irq_pkg::EN_SLEEP] & enhanced; // RL6

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence enableWritten;
    regWr && regAddr == uart_irq_pkg::ADDR_ENABLE;
  endsequence

  sequence identifyRead;
    regRd && regAddr == uart_irq_pkg::ADDR_IDENTIFY;
  endsequence

  sequence ctsRiseSeen;
    cts && !st_ff.ctsPrev && enhanced && st_ff.enable[uart_irq_pkg::EN_CTS];
  endsequence

  // a refused rise must not be remembered for later
  sequence rtsRiseRefused;
    rts && !st_ff.rtsPrev && !(enhanced && st_ff.enable[uart_irq_pkg::EN_RTS]);
  endsequence

  a_enable_store: assert property ( // RL1
    enableWritten |=> st_ff.enable == $past(regWrData))
    else $error("enable register did not take the written byte");

  a_masked_quiet: assert property ( // RL2
    (st_ff.enable == 8'h00 && !st_ff.flowFlag) |=> !irqOut)
    else $error("interrupt raised with every source masked");

  a_cts_rise_irq: assert property ( // RL3
    ctsRiseSeen ##1 (!msrRead && !(regRd && regAddr == uart_irq_pkg::ADDR_IDENTIFY))
    |=> irqOut && st_ff.level != uart_irq_pkg::LVL_NONE)
    else $error("cts rising edge did not raise the interrupt");

  a_sleep_follow: assert property ( // RL6
    (enableWritten and regWrData[uart_irq_pkg::EN_SLEEP]) ##1 enhanced |-> sleepMode)
    else $error("sleep mode not entered after enable write");

  a_lsr_first: assert property ( // RL8
    (st_ff.lineErr != 4'h0 && enhanced && st_ff.enable[uart_irq_pkg::EN_LSR])
    |=> irqOut && st_ff.level == uart_irq_pkg::LVL_LSR)
    else $error("line status did not take top priority");

  a_overrun_now: assert property ( // RL9
    overrunEvt |=> st_ff.lineErr[0])
    else $error("overrun flag not set on the overflowing frame");

  a_thr_clear: assert property ( // RL23
    (txWrite && !(txEmpty && !st_ff.txEmptyPrev)) |=> !st_ff.thrFlag)
    else $error("transmit empty flag survived a transmit write");

  a_tout_fire: assert property ( // RL25
    (counting && bitTick && st_ff.toutCnt == TOUT_CNT - 8'h01) |=> st_ff.toutFlag)
    else $error("receive time-out did not fire at the limit");

  a_read_frozen: assert property ( // RL15
    identifyRead |=> regRdData[5:0] == levelCode($past(st_ff.level)))
    else $error("identify read did not return the frozen level");

  a_fifo_bits: assert property ( // RL16
    identifyRead |=> regRdData[7:6] == {2{$past(fifoEnable)}})
    else $error("identify bits 7:6 do not mirror fifo enable");

  a_irq_vs_id: assert property ( // RL27
    identifyRead |=> regRdData[0] == !$past(irqOut))
    else $error("irqOut disagrees with identify bit 0");

  a_rts_refused: assert property ( // RL4
    rtsRiseRefused ##0 (!st_ff.flowFlag && !(cts && !st_ff.ctsPrev)) |=> !st_ff.flowFlag)
    else $error("refused rts rise was remembered");

  a_flow_msr_clear: assert property ( // RL17
    (msrRead && !(cts && !st_ff.ctsPrev) && !(rts && !st_ff.rtsPrev)) |=> !st_ff.flowFlag)
    else $error("modem status read left the flow flag set");

  a_xon_clear: assert property ( // RL26
    (xonMatch && !xoffMatch && !specialMatch) |=> !st_ff.xoffFlag)
    else $error("resume character did not clear the stop flag");

  a_special_next: assert property ( // RL26
    (st_ff.xoffSpecial && rxCharEvt && !xoffMatch && !specialMatch) |=> !st_ff.xoffFlag)
    else $error("special character flag survived the next character");

  a_tout_clear: assert property ( // RL25
    rxDataRead |=> !st_ff.toutFlag)
    else $error("receive data read did not clear the time-out");

  a_lsr_clear: assert property ( // RL8
    (lsrRead && !overrunEvt && !errRead) |=> st_ff.lineErr == 4'h0)
    else $error("line status read did not clear the error bits");

  a_rxdata_raise: assert property ( // RL12
    (st_ff.enable[uart_irq_pkg::EN_RXDATA] && rxFill != '0 && rxFill >= rxTrig) |=> irqOut)
    else $error("waiting receive data did not raise the interrupt");

  a_modem_raise: assert property ( // RL7
    (st_ff.enable[uart_irq_pkg::EN_MODEM] && msrDelta != 4'h0) |=> irqOut)
    else $error("modem status change did not raise the interrupt");

  a_thr_raise: assert property ( // RL11
    (st_ff.enable[uart_irq_pkg::EN_THR] && st_ff.thrFlag) |=> irqOut)
    else $error("transmit empty did not raise the interrupt");

  a_sleep_gate: assert property ( // RL6
    !enhanced |-> !sleepMode)
    else $error("sleep mode active without the enhanced enable");

endmodule
`default_nettype wire

/* host_bus_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// host side of the register bus
// ==========================================================================
module host_bus_model (
  input  wire logic       clk,
  output logic      [2:0] regAddr,
  output logic      [7:0] regWrData,
  output logic            regWr,
  output logic            regRd
);
  initial begin
    regAddr   = 3'h0;
    regWrData = 8'h00;
    regWr     = 1'b0;
    regRd     = 1'b0;
  end

  // a leading edge keeps back-to-back calls from assigning a strobe twice
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge clk);
    regWr     <= 1'b0;
    regWrData <= ~d;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd   <= 1'b0;
    regAddr <= ~a;
  endtask
endmodule
`default_nettype wire

/* test_uart_channel_interrupt_logic.sv */
`timescale 1ns/10ps
`default_nettype none
module test_uart_channel_interrupt_logic;
  logic       clk = 1'b0;
  logic       resetn, regWr, regRd, enhanced, fifoEnable, overrunEvt, errRead, lsrRead;
  logic       rxCharEvt, rxDataRead, bitTick, txEmpty, txWrite, msrRead, xoffMatch;
  logic       specialMatch, xonMatch, cts, rts, irqOut, sleepMode, rdPend = 1'b0;
  logic [2:0] regAddr, errBits;
  logic [7:0] regWrData, regRdData;
  logic [6:0] rxFill, rxTrig;
  logic [3:0] msrDelta, lineErr;
  logic [7:0] expQ[$];
  int         num_errors = 0;
  int         checks = 0;
  int         rv;
  logic [7:0] enTab[9] = '{8'h04, 8'h04, 8'h01, 8'h02, 8'h08, 8'h20, 8'h80, 8'h40, 8'h20};
  logic [5:0] idTab[9] = '{6'h06, 6'h06, 6'h04, 6'h02, 6'h00, 6'h10, 6'h20, 6'h20, 6'h10};

  always #4 clk = ~clk;

  host_bus_model host (.clk(clk), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
                       .regRd(regRd));

  // two character bits keep the receive time-out short
  uart_channel_interrupt_logic #(.CHAR_BITS(2), .FIFO_CNT_W(7)) DUT (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .enhanced(enhanced), .fifoEnable(fifoEnable),
    .overrunEvt(overrunEvt), .errRead(errRead), .errBits(errBits), .lsrRead(lsrRead),
    .rxFill(rxFill), .rxTrig(rxTrig), .rxCharEvt(rxCharEvt), .rxDataRead(rxDataRead),
    .bitTick(bitTick), .txEmpty(txEmpty), .txWrite(txWrite), .msrDelta(msrDelta),
    .msrRead(msrRead), .xoffMatch(xoffMatch), .specialMatch(specialMatch),
    .xonMatch(xonMatch), .cts(cts), .rts(rts), .irqOut(irqOut), .sleepMode(sleepMode),
    .lineErr(lineErr));

  // ==========================================================================
  // checking
  // ==========================================================================
  task automatic report_and_stop;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk) rdPend <= regRd;
  always @(negedge clk) begin
    if (rdPend) begin
      if (expQ.size() == 0)
        chk(regRdData, 8'hxx);
      else
        chk(regRdData, expQ.pop_front());
    end
  end

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host.rd(a);
  endtask

  task automatic settle(input int n, input logic [7:0] irqExp);
    repeat (n) @(posedge clk);
    @(negedge clk);
    chk({7'h0, irqOut}, irqExp);
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (irqOut !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk({7'h0, irqOut}, 8'h01);
    if (n >= 100)
      report_and_stop;
  endtask

  // ==========================================================================
  // stimulus
  // ==========================================================================
  task automatic do_reset(input logic f);
    // one edge first, so the last read data are checked before reset clears them
    @(posedge clk);
    resetn <= 1'b0;
    {fifoEnable, enhanced, overrunEvt, errRead, lsrRead, rxCharEvt} <= {f, 5'h10};
    {rxDataRead, bitTick, txEmpty, txWrite, msrRead, xoffMatch} <= 6'h00;
    {specialMatch, xonMatch, cts, rts, errBits, msrDelta} <= 11'h000;
    rxFill <= 7'h00;
    rxTrig <= 7'h01;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
  endtask

  task automatic src(input int s, input logic v);
    case (s)
      0: overrunEvt <= v;
      1: begin
        errBits <= 3'h5;
        errRead <= v;
      end
      2: rxFill <= {6'h00, v};
      3: txEmpty <= v;
      4: msrDelta <= {3'h0, v};
      5: xoffMatch <= v;
      6: cts <= v;
      7: rts <= v;
      default: specialMatch <= v;
    endcase
  endtask

  initial begin
    logic       f;
    logic [7:0] v;
    rv = $urandom(32204);
    resetn <= 1'b0;
    do_reset(1'b0);
    rd(3'h1, 8'h00);
    rd(3'h2, 8'h01);
    v = 8'($urandom());
    host.wr(3'h1, v);
    host.wr(3'h2, ~v);
    rd(3'h1, v);
    rd(3'h5, 8'h00);
    // each source except the receive time-out alone, masked and then unmasked
    for (int s = 0; s < 9; s++) begin
      for (int m = 0; m < 2; m++) begin
        f = 1'($urandom());
        do_reset(f);
        host.wr(3'h1, m ? enTab[s] : 8'h00);
        @(posedge clk);
        src(s, 1'b1);
        @(posedge clk);
        if (s < 2 || s > 4)
          src(s, 1'b0);
        if (m) begin
          wait_irq();
          rd(3'h2, {f, f, idTab[s]});
        end else begin
          settle(6, 8'h00);
          rd(3'h2, {f, f, 6'h01});
        end
        @(negedge clk);
        chk({4'h0, lineErr}, s == 0 ? 8'h01 : (s == 1 ? 8'h0a : 8'h00));
        if (m && (s == 3 || s > 4)) begin
          rd(3'h2, {f, f, 6'h01});
          settle(2, 8'h00);
        end
      end
    end
    @(posedge clk);
    errBits <= 3'h5;
    errRead <= 1'b1;
    @(posedge clk);
    errRead <= 1'b0;
    @(negedge clk);
    chk({4'h0, lineErr}, 8'h0a);
    @(posedge clk);
    lsrRead <= 1'b1;
    @(posedge clk);
    lsrRead <= 1'b0;
    settle(2, 8'h00);
    chk({4'h0, lineErr}, 8'h00);
    // priority and clear on presentation
    do_reset(1'b0);
    host.wr(3'h1, 8'hff);
    @(posedge clk);
    txEmpty  <= 1'b1;
    msrDelta <= 4'h2;
    xoffMatch <= 1'b1;
    @(posedge clk);
    xoffMatch <= 1'b0;
    settle(4, 8'h01);
    rd(3'h2, 8'h02);
    rd(3'h2, 8'h00);
    @(posedge clk);
    msrDelta <= 4'h0;
    settle(3, 8'h01);
    rd(3'h2, 8'h10);
    rd(3'h2, 8'h01);
    // flow flag leaves on a modem status read, stop and special on later characters
    @(posedge clk);
    cts <= 1'b1;
    settle(2, 8'h01);
    @(posedge clk);
    msrRead <= 1'b1;
    @(posedge clk);
    msrRead <= 1'b0;
    settle(2, 8'h00);
    @(posedge clk);
    specialMatch <= 1'b1;
    @(posedge clk);
    specialMatch <= 1'b0;
    settle(2, 8'h01);
    @(posedge clk);
    rxCharEvt <= 1'b1;
    @(posedge clk);
    rxCharEvt <= 1'b0;
    settle(2, 8'h00);
    @(posedge clk);
    xoffMatch <= 1'b1;
    @(posedge clk);
    xoffMatch <= 1'b0;
    settle(2, 8'h01);
    @(posedge clk);
    xonMatch <= 1'b1;
    @(posedge clk);
    xonMatch <= 1'b0;
    settle(2, 8'h00);
    // sleep mode needs the enhanced enable
    do_reset(1'b0);
    host.wr(3'h1, 8'h10);
    @(posedge clk);
    @(negedge clk);
    chk({7'h0, sleepMode}, 8'h01);
    @(posedge clk);
    enhanced <= 1'b0;
    @(negedge clk);
    chk({7'h0, sleepMode}, 8'h00);
    cts <= 1'b0;
    host.wr(3'h1, 8'h80);
    @(posedge clk);
    cts <= 1'b1;
    settle(6, 8'h00);
    rd(3'h2, 8'h01);
    // receive time-out then trigger level, FIFO mode
    do_reset(1'b1);
    rxTrig <= 7'h04;
    rxFill <= 7'h01;
    host.wr(3'h1, 8'h01);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      bitTick <= 1'b1;
      @(posedge clk);
      bitTick <= 1'b0;
      if (i == 10)
        settle(0, 8'h00);
    end
    wait_irq();
    rd(3'h2, 8'hcc);
    @(posedge clk);
    rxDataRead <= 1'b1;
    @(posedge clk);
    rxDataRead <= 1'b0;
    settle(3, 8'h00);
    rxFill <= 7'h04;
    settle(3, 8'h01);
    rd(3'h2, 8'hc4);
    rxFill <= 7'h03;
    settle(3, 8'h00);
    rd(3'h2, 8'hc1);
    settle(2, 8'h00);
    report_and_stop;
  end

  initial begin
    #400000;
    num_errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
